// File: design/pin_state_ctrl.sv
// Purpose: Pin states and external bus outputs across reset, standby and sleep.
// Assumes: AHB-Lite single word transfers; reset pin synchronous to hclk.
// Notes: Bus state advances one state per clock; status errors clear by writing one.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module pin_state_ctrl (
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic [31:0]                  hrdata,
	input  wire logic                    reset_in_n,
	input  wire logic                    hw_standby_n,
	input  wire logic                    wdt_overflow,
	input  wire logic                    sleep_req,
	input  wire pin_state_pkg::bus_state_t bus_state,
	input  wire logic                    two_state_area,
	input  wire pin_state_pkg::core_bus_t core_bus,
	output pin_state_pkg::ext_bus_t      ext_bus,
	output pin_state_pkg::port_pins_t    port_pins,
	output logic                         clk_out_run,
	output logic                         clk_out_level,
	output logic                         clk_out_oe,
	output logic                         reset_out_n,
	output logic                         reset_out_oe
);
	import pin_state_pkg::*;

	logic [2:0]          ctrl_reg;
	logic [PORT_W-1:0]   dir_reg;
	logic [PORT_W-1:0]   data_reg;
	logic                entry_err_reg;
	logic                exit_err_reg;
	logic                wdt_reset_reg;
	logic                res_fall_reg;
	logic                hold_reg;
	logic                hold_done_reg;
	logic [ADDR_W-1:0]   addr_reg;
	logic                addr_oe_reg;
	power_mode_t         mode_reg;
	power_mode_t         mode_next;
	logic [LEAD_CNT_W-1:0] lead_reg;
	logic                hw_standby_n_prev_reg;
	logic                wr_pend_reg;
	logic [7:0]          wr_addr_reg;
	logic                ram_en;
	logic                addr_mode;
	logic                rst_now;
	logic                hw_hw_standby_n;
	logic                hold_state;
	logic                bus_wr;
	logic [31:0]         status_word;

	assign ram_en    = ctrl_reg[CTRL_RAM_EN_BIT];
	assign addr_mode = ctrl_reg[CTRL_ADDR_MODE_BIT];
	assign hw_hw_standby_n   = !hw_standby_n;
	assign rst_now   = !reset_in_n;

	// Reset caught on the falling edge so the address clears half a state later
	always_ff @(negedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_fall_reg <= 1'b0;
		end else begin
			res_fall_reg <= !reset_in_n;
		end
	end

	// Third state, or second of a two-state area, keeps its address
	assign hold_state = (bus_state == BUS_T3) ||
		((bus_state == BUS_T2) && two_state_area);

	// Hold is decided once, at the first edge of a reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_reg      <= 1'b0;
			hold_done_reg <= 1'b0;
		end else if (res_fall_reg && !hold_done_reg) begin
			hold_reg      <= hold_state && rst_now;
			hold_done_reg <= 1'b1;
		end else if (!res_fall_reg) begin
			hold_reg      <= 1'b0;
			hold_done_reg <= 1'b0;
		end else begin
			hold_reg      <= 1'b0;
		end
	end

	// Address register; T1, wait states and T2 outside a two-state area clear it a half state after sampling
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_reg    <= '0;
			addr_oe_reg <= 1'b1;
		end else if (res_fall_reg) begin
			if (!hold_done_reg && hold_state && rst_now) begin
				addr_reg <= addr_reg;
			end else begin
				// Held address lasts one state only, then clears
				addr_reg <= '0;
			end
			addr_oe_reg <= 1'b1;
		end else begin
			addr_reg    <= core_bus.addr;
			addr_oe_reg <= !hw_hw_standby_n && (mode_reg != MODE_SW_HW_STANDBY_N);
		end
	end

	// Power mode; hardware standby outranks reset, reset outranks software modes
	always_comb begin
		mode_next = MODE_RUN;
		if (hw_hw_standby_n) begin
			mode_next = MODE_HW_HW_STANDBY_N;
		end else if (rst_now) begin
			mode_next = MODE_RESET;
		end else if (sleep_req) begin
			mode_next = ctrl_reg[CTRL_SW_HW_STANDBY_N_BIT] ? MODE_SW_HW_STANDBY_N : MODE_SLEEP;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_reg <= MODE_RESET;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// Cycles that reset has been low, for the standby sequencing checks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lead_reg      <= '0;
			hw_standby_n_prev_reg <= 1'b0;
		end else begin
			hw_standby_n_prev_reg <= hw_hw_standby_n;
			if (!rst_now) begin
				lead_reg <= '0;
			end else if (lead_reg != {LEAD_CNT_W{1'b1}}) begin
				lead_reg <= lead_reg + 1'b1;
			end
		end
	end

	// Watchdog cause is latched so the reset output knows whether to pull low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdt_reset_reg <= 1'b0;
		end else if (wdt_overflow) begin
			wdt_reset_reg <= 1'b1;
		end else if (!rst_now && !res_fall_reg) begin
			wdt_reset_reg <= 1'b0;
		end
	end

	// AHB-Lite: zero wait, writes land in the data phase
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign bus_wr    = hsel && hready && htrans[1] && hwrite;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
		end else if (hready) begin
			wr_pend_reg <= bus_wr && (hsize == 3'h2);
			wr_addr_reg <= haddr[7:0];
		end
	end

	// Control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= CTRL_RESET_VAL;
		end else if (wr_pend_reg && wr_addr_reg == CTRL_OFFSET) begin
			ctrl_reg <= hwdata[2:0];
		end
	end

	// Direction and output data; a reset turns every pin to input
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_reg  <= '0;
			data_reg <= '0;
		end else if (res_fall_reg) begin
			dir_reg  <= '0;
		end else if (wr_pend_reg && mode_reg == MODE_RUN) begin
			// Frozen outside run so kept levels really stay put
			if (wr_addr_reg == DIR_OFFSET) begin
				dir_reg <= hwdata[PORT_W-1:0];
			end
			if (wr_addr_reg == DATA_OFFSET) begin
				data_reg <= hwdata[PORT_W-1:0];
			end
		end
	end

	// Sequencing errors; a new error wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			entry_err_reg <= 1'b0;
			exit_err_reg  <= 1'b0;
		end else begin
			if (hw_hw_standby_n && !hw_standby_n_prev_reg && ram_en &&
				lead_reg < LEAD_CNT_W'(ENTRY_LEAD_CYCLES)) begin
				entry_err_reg <= 1'b1;
			end else if (wr_pend_reg && wr_addr_reg == STATUS_OFFSET &&
				hwdata[ST_ENTRY_ERR_BIT]) begin
				entry_err_reg <= 1'b0;
			end
			if (!hw_hw_standby_n && hw_standby_n_prev_reg &&
				lead_reg < LEAD_CNT_W'(EXIT_LEAD_CYCLES)) begin
				exit_err_reg <= 1'b1;
			end else if (wr_pend_reg && wr_addr_reg == STATUS_OFFSET &&
				hwdata[ST_EXIT_ERR_BIT]) begin
				exit_err_reg <= 1'b0;
			end
		end
	end

	// Read data registered in the address phase
	always_comb begin
		status_word = '0;
		status_word[ST_RES_SAMPLED_BIT] = res_fall_reg;
		status_word[ST_WDT_RESET_BIT]   = wdt_reset_reg;
		status_word[ST_ENTRY_ERR_BIT]   = entry_err_reg;
		status_word[ST_EXIT_ERR_BIT]    = exit_err_reg;
		status_word[ST_MODE_LSB +: 3]   = mode_reg;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (hsel && hready && htrans[1] && !hwrite) begin
			unique case (haddr[7:0])
				CTRL_OFFSET:   hrdata <= {29'h0, ctrl_reg};
				DIR_OFFSET:    hrdata <= {16'h0, dir_reg};
				DATA_OFFSET:   hrdata <= {16'h0, data_reg};
				STATUS_OFFSET: hrdata <= status_word;
				default:       hrdata <= 32'h0;
			endcase
		end
	end

	// External bus pins; strobes and data react at once to the reset pin
	always_comb begin
		ext_bus.addr          = addr_reg;
		ext_bus.addr_oe       = addr_oe_reg && !hw_hw_standby_n;
		ext_bus.addr_strobe_n = core_bus.as_n || rst_now;
		ext_bus.rd_n          = core_bus.rd_n || rst_now;
		ext_bus.wr_n          = core_bus.wr_n || rst_now;
		ext_bus.data          = core_bus.data;
		ext_bus.data_oe       = core_bus.data_oe && !rst_now && !hw_hw_standby_n;
	end

	// Port pins; inputs float, outputs keep their last level except in reset and hardware standby, where all float
	always_comb begin
		port_pins.level = data_reg;
		port_pins.oe    = dir_reg;
		if (rst_now || res_fall_reg || hw_hw_standby_n) begin
			port_pins.oe = '0;
		end else if (addr_mode && mode_reg != MODE_SW_HW_STANDBY_N) begin
			port_pins.level[PA_HI_LSB +: 4] = addr_reg[ADDR_HI_LSB +: 4];
			port_pins.oe[PA_HI_LSB +: 4]    = 4'hf;
		end
	end

	// Clock pin and reset output pin
	always_comb begin
		clk_out_run   = !hw_hw_standby_n && (mode_reg != MODE_SW_HW_STANDBY_N);
		clk_out_level = (mode_reg == MODE_SW_HW_STANDBY_N);
		clk_out_oe    = !hw_hw_standby_n;
		reset_out_n   = 1'b0;
		reset_out_oe  = rst_now && wdt_reset_reg && !hw_hw_standby_n;
	end

	a_strobes_high: assert property (@(posedge hclk) disable iff (!hresetn)
		!reset_in_n |-> ext_bus.addr_strobe_n && ext_bus.rd_n && ext_bus.wr_n && !ext_bus.data_oe)
		else $error("strobes not released on reset");
	a_ports_input: assert property (@(posedge hclk) disable iff (!hresetn)
		!reset_in_n |-> port_pins.oe == '0)
		else $error("port driven during reset");
	a_addr_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(res_fall_reg) && !(hold_state && !reset_in_n) |=> addr_reg == '0)
		else $error("address not cleared after reset");
	a_sample_edge: assert property (@(negedge hclk) disable iff (!hresetn)
		1'b1 |=> res_fall_reg == !$past(reset_in_n))
		else $error("reset not sampled on falling edge");
	a_addr_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		res_fall_reg && !hold_done_reg && hold_state && !reset_in_n
		|=> addr_reg == $past(addr_reg))
		else $error("address not held in third state");
	a_entry_check: assert property (@(posedge hclk) disable iff (!hresetn)
		!hw_standby_n && !hw_standby_n_prev_reg && ram_en &&
		lead_reg < LEAD_CNT_W'(ENTRY_LEAD_CYCLES) |=> entry_err_reg)
		else $error("short reset lead before standby missed");
	a_exit_check: assert property (@(posedge hclk) disable iff (!hresetn)
		hw_standby_n && hw_standby_n_prev_reg &&
		lead_reg < LEAD_CNT_W'(EXIT_LEAD_CYCLES) |=> exit_err_reg)
		else $error("short reset lead before standby exit missed");
	a_reset_out: assert property (@(posedge hclk) disable iff (!hresetn)
		reset_out_oe |-> !reset_in_n && wdt_reset_reg)
		else $error("reset output driven without watchdog cause");
	a_hw_hw_standby_n_float: assert property (@(posedge hclk) disable iff (!hresetn)
		!hw_standby_n |-> !clk_out_oe && port_pins.oe == '0 && !ext_bus.addr_oe)
		else $error("pins driven in hardware standby");
	a_keep_level: assert property (@(posedge hclk) disable iff (!hresetn)
		mode_reg == MODE_SLEEP && $past(mode_reg == MODE_SLEEP) && !addr_mode
		|-> port_pins.level == $past(port_pins.level))
		else $error("kept level changed in sleep");

	c_reset_t3:   cover property (@(posedge hclk) res_fall_reg && hold_state && !hold_done_reg);
	c_reset_t1:   cover property (@(posedge hclk) $rose(res_fall_reg) && bus_state == BUS_T1);
	c_hw_hw_standby_n:    cover property (@(posedge hclk) $rose(!hw_standby_n) && !reset_in_n);
	c_sw_hw_standby_n:    cover property (@(posedge hclk) mode_reg == MODE_SW_HW_STANDBY_N);
	c_wdt_reset:  cover property (@(posedge hclk) reset_out_oe);

endmodule // pin_state_ctrl

// File: design/pin_state_pkg.sv
// Purpose: Constants and carriers for the reset and standby pin-state controller.
// Assumes: One clock at 40 MHz; one bus state per clock cycle.
// Notes: Register map and field positions are local choices.
// Function
// - All port pins become inputs on reset
// - Reset forces strobes high, data bus released
// - Reset in T1/T2 clears address half-state later
// - Reset input sampled on falling clock edge
// - Wait-state reset treated like second state
// - Reset in third state holds address
// - Two-state area second state holds address
// - Standby/sleep: inputs float, outputs keep levels; the code floats every port pin in hardware standby
// - Reset output floats, low on watchdog reset
// - Upper port A: address mode standby/sleep behaviour
package pin_state_pkg;

	// Register byte addresses
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] DIR_OFFSET    = 8'h04;
	localparam logic [7:0] DATA_OFFSET   = 8'h08;
	localparam logic [7:0] STATUS_OFFSET = 8'h0c;

	// Control field positions
	localparam int CTRL_RAM_EN_BIT    = 0;
	localparam int CTRL_ADDR_MODE_BIT = 1;
	localparam int CTRL_SW_HW_STANDBY_N_BIT   = 2;
	localparam logic [2:0] CTRL_RESET_VAL = 3'h0;

	// Status field positions
	localparam int ST_RES_SAMPLED_BIT = 0;
	localparam int ST_WDT_RESET_BIT   = 1;
	localparam int ST_ENTRY_ERR_BIT   = 2;
	localparam int ST_EXIT_ERR_BIT    = 3;
	localparam int ST_MODE_LSB        = 4;

	localparam int PORT_W = 16;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int ADDR_HI_LSB = 20;
	localparam int PA_HI_LSB   = 4;

	// Sequencing times
	localparam int CLK_PERIOD_NS      = 25;
	localparam int ENTRY_LEAD_CYCLES  = 10;
	localparam int EXIT_LEAD_NS       = 100;
	localparam int EXIT_LEAD_CYCLES   = (EXIT_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LEAD_CNT_W         = 5;

	typedef enum logic [2:0] {
		MODE_RUN     = 3'b000,
		MODE_SLEEP   = 3'b001,
		MODE_SW_HW_STANDBY_N = 3'b010,
		MODE_HW_HW_STANDBY_N = 3'b011,
		MODE_RESET   = 3'b100
	} power_mode_t;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b000,
		BUS_T1   = 3'b001,
		BUS_T2   = 3'b010,
		BUS_T3   = 3'b011,
		BUS_TW   = 3'b100
	} bus_state_t;

	// Core side of the external bus
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              as_n;
		logic              rd_n;
		logic              wr_n;
		logic [DATA_W-1:0] data;
		logic              data_oe;
	} core_bus_t;

	// External bus pins
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              addr_oe;
		logic              addr_strobe_n;
		logic              rd_n;
		logic              wr_n;
		logic [DATA_W-1:0] data;
		logic              data_oe;
	} ext_bus_t;

	// General-purpose port pins
	typedef struct packed {
		logic [PORT_W-1:0] level;
		logic [PORT_W-1:0] oe;
	} port_pins_t;

endpackage

// File: verification/bus_far_side.sv
// Purpose: Far-side model of the core bus controller feeding the pin-state block.
// Assumes: One bus state per hclk; every access is a write so address strobe, write strobe and data move.
// Notes: Drops to idle while the pin reset is low, like the real core would.
`timescale 1ns/1ps
module bus_far_side (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 reset_in_n,
	input  wire logic                 two_state,
	input  wire logic                 waits,
	output pin_state_pkg::bus_state_t bus_state,
	output logic                      two_state_area,
	output pin_state_pkg::core_bus_t  core_bus
);
	import pin_state_pkg::*;
	bus_state_t        st_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic              wr_n;

	// Access sequencer; fresh random address at each start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= BUS_IDLE;
		end else if (!reset_in_n) begin
			st_reg <= BUS_IDLE;
		end else begin
			case (st_reg)
				BUS_IDLE: st_reg <= BUS_T1;
				BUS_T1:   st_reg <= BUS_T2;
				BUS_T2:   st_reg <= two_state ? BUS_IDLE : (waits ? BUS_TW : BUS_T3);
				BUS_TW:   st_reg <= BUS_T3;
				default:  st_reg <= BUS_IDLE;
			endcase
		end
	end

	// Address only changes between accesses
	always_ff @(posedge hclk) begin
		if (st_reg == BUS_IDLE) begin
			addr_reg <= ADDR_W'($urandom);
		end
	end

	// Address and write strobes low inside the access so the block must override them; read strobe stays high
	assign wr_n           = (st_reg == BUS_IDLE) || (st_reg == BUS_T1);
	assign bus_state      = st_reg;
	assign two_state_area = two_state;
	assign core_bus       = '{addr: addr_reg, as_n: st_reg == BUS_IDLE, rd_n: 1'b1,
		wr_n: wr_n, data: addr_reg[15:0], data_oe: !wr_n};
endmodule // bus_far_side

// File: verification/tb_pin_state_ctrl.sv
// Purpose: Self-checking bench for the reset and standby pin-state controller.
// Assumes: Zero-wait AHB-Lite slave; the bench plays board reset and standby control.
// Notes: Drivers queue notes after a rising edge; the monitor checks them at the falling edge.
`timescale 1ns/1ps
module tb_pin_state_ctrl;
	import pin_state_pkg::*;
	typedef struct packed {logic [3:0] sel; logic [31:0] exp; logic [31:0] msk;} note_t;
	logic        hclk, hresetn = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [1:0]  htrans = 2'b00;
	logic [2:0]  hsize  = 3'h2;
	logic [31:0] haddr  = 32'h0, hwdata = 32'h0, hrdata, d, v, a;
	logic        reset_in_n = 1'b1, hw_standby_n = 1'b1, wdt_overflow = 1'b0;
	logic        sleep_req = 1'b0, two_state = 1'b0, waits = 1'b0;
	logic        clk_out_run, clk_out_level, clk_out_oe, reset_out_n, reset_out_oe;
	logic        two_state_area;
	bus_state_t  bus_state;
	core_bus_t   core_bus;
	ext_bus_t    ext_bus;
	port_pins_t  port_pins;
	note_t       notes[$];
	note_t       cur;
	int          fails, samples_checked, cycles, i, k;
	// Reset-in-access cases: T1, T2, TW, T3, two-state T2, T1 with watchdog cause
	bus_state_t  pred_t [6] = '{BUS_IDLE, BUS_T1, BUS_T2, BUS_T2, BUS_T1, BUS_IDLE};
	logic        tsa_t  [6] = '{0, 0, 0, 0, 1, 0};
	logic        wt_t   [6] = '{0, 0, 1, 0, 0, 0};
	logic        hold_t [6] = '{0, 0, 0, 1, 1, 0};
	// Standby cases: good, short entry lead, RAM off with short exit lead
	logic        ram_h  [3] = '{1, 1, 0};
	int          in_h   [3] = '{11, 8, 0};
	int          out_h  [3] = '{5, 5, 2};
	logic [31:0] err_h  [3] = '{32'h0, 32'h4, 32'h8};

	pin_state_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reset_in_n(reset_in_n),
		.hw_standby_n(hw_standby_n), .wdt_overflow(wdt_overflow), .sleep_req(sleep_req),
		.bus_state(bus_state), .two_state_area(two_state_area), .core_bus(core_bus),
		.ext_bus(ext_bus), .port_pins(port_pins), .clk_out_run(clk_out_run),
		.clk_out_level(clk_out_level), .clk_out_oe(clk_out_oe), .reset_out_n(reset_out_n),
		.reset_out_oe(reset_out_oe));
	bus_far_side far (.hclk(hclk), .hresetn(hresetn), .reset_in_n(reset_in_n),
		.two_state(two_state), .waits(waits), .bus_state(bus_state),
		.two_state_area(two_state_area), .core_bus(core_bus));

	// Clock at 40 MHz
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// Observed value for each note selector
	function automatic logic [31:0] obs(input logic [3:0] s);
		case (s)
			4'h0: obs = hrdata;
			4'h1: obs = 32'(port_pins.oe);
			4'h2: obs = 32'(port_pins.level);
			4'h3: obs = {28'h0, ext_bus.addr_strobe_n, ext_bus.rd_n, ext_bus.wr_n, ext_bus.data_oe};
			4'h4: obs = 32'(ext_bus.addr);
			4'h5: obs = {30'h0, reset_out_n, reset_out_oe};
			default: obs = {29'h0, clk_out_run, clk_out_level, clk_out_oe};
		endcase
	endfunction

	// Monitor: falling edge sees settled outputs of the cycle noted
	always @(negedge hclk) begin
		while (notes.size() > 0) begin
			cur = notes.pop_front();
			samples_checked++;
			if ((obs(cur.sel) & cur.msk) !== (cur.exp & cur.msk)) begin
				fails++;
				$display("ERROR %0t sel %0d got %h exp %h", $time, cur.sel, obs(cur.sel), cur.exp);
			end
		end
	end

	// Hang guard, well above the few hundred cycles used
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			$display("ERROR %0t run did not finish", $time);
			close_out();
		end
	end

	task automatic note(input logic [3:0] s, input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{s, e, m});
	endtask

	// One AHB single transfer; on reads dt is the expected word
	task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] dt,
		input logic [2:0] sz, input logic [31:0] m);
		@(posedge hclk);
		haddr  <= {24'h0, ad};
		htrans <= 2'b10;
		hwrite <= w;
		hsize  <= sz;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= dt;
		if (!w) note(4'h0, dt, m);
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		ahb(1'b1, ad, dt, 3'h2, 32'h0);
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
		ahb(1'b0, ad, e, 3'h2, m);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Main sequence
	initial begin
		d = $urandom(88752);
		tick(2);
		hresetn <= 1'b1;
		// Reset values, unmapped place, narrow write refused
		rd(CTRL_OFFSET, 32'h0, 32'hffffffff);
		rd(DIR_OFFSET, 32'h0, 32'hffffffff);
		wr(8'h10, 32'hffffffff);
		rd(8'h10, 32'h0, 32'hffffffff);
		d = $urandom;
		v = $urandom;
		wr(DIR_OFFSET, d);
		wr(DATA_OFFSET, v);
		ahb(1'b1, DATA_OFFSET, ~v, 3'h1, 32'h0);
		rd(DATA_OFFSET, {16'h0, v[15:0]}, 32'hffffffff);
		note(4'h1, d, 32'hffff);
		note(4'h2, v, 32'hffff);
		// Pin reset landing in each bus state of a live access
		for (i = 0; i < 6; i++) begin
			if (i == 5) wdt_overflow <= 1'b1;
			wr(DIR_OFFSET, 32'hffff);
			two_state <= tsa_t[i];
			waits <= wt_t[i];
			k = 0;
			do begin @(negedge hclk); k++; end while (bus_state !== pred_t[i] && k < 50);
			a = 32'(core_bus.addr);
			@(posedge hclk);
			reset_in_n <= 1'b0;
			wdt_overflow <= 1'b0;
			note(4'h3, 32'he, 32'hf);
			note(4'h1, 32'h0, 32'hffff);
			note(4'h5, {31'h0, i == 5}, 32'h3);
			@(posedge hclk);
			note(4'h4, hold_t[i] ? a : 32'h0, 32'hffffff);
			@(posedge hclk);
			note(4'h4, 32'h0, 32'hffffff);
			tick(2);
			reset_in_n <= 1'b1;
			rd(DIR_OFFSET, 32'h0, 32'hffff);
		end
		// Sleep then software standby with port A upper in address mode
		d = $urandom;
		v = $urandom;
		wr(DIR_OFFSET, d);
		wr(DATA_OFFSET, v);
		wr(CTRL_OFFSET, 32'h2);
		sleep_req <= 1'b1;
		tick(3);
		note(4'h1, {16'h0, d[15:8], 4'hf, d[3:0]}, 32'hffff);
		note(4'h6, 32'h5, 32'h5);
		rd(STATUS_OFFSET, 32'h10, 32'h70);
		wr(DATA_OFFSET, ~v);
		sleep_req <= 1'b0;
		tick(3);
		wr(CTRL_OFFSET, 32'h6);
		sleep_req <= 1'b1;
		tick(3);
		note(4'h1, d, 32'hffff);
		note(4'h2, v, 32'hffff);
		note(4'h6, 32'h3, 32'h7);
		rd(STATUS_OFFSET, 32'h20, 32'h70);
		// Second reset in mid-run
		hresetn <= 1'b0;
		sleep_req <= 1'b0;
		tick(2);
		hresetn <= 1'b1;
		// Hardware standby entry and exit sequences
		for (i = 0; i < 3; i++) begin
			wr(CTRL_OFFSET, {31'h0, ram_h[i]});
			if (in_h[i] > 0) reset_in_n <= 1'b0;
			tick(in_h[i]);
			hw_standby_n <= 1'b0;
			tick(1);
			reset_in_n <= 1'b1;
			tick(2);
			note(4'h6, 32'h0, 32'h1);
			note(4'h1, 32'h0, 32'hffff);
			rd(STATUS_OFFSET, 32'h30, 32'h70);
			reset_in_n <= 1'b0;
			tick(out_h[i]);
			hw_standby_n <= 1'b1;
			tick(1);
			reset_in_n <= 1'b1;
			tick(2);
			rd(STATUS_OFFSET, err_h[i], 32'hc);
			wr(STATUS_OFFSET, 32'hc);
			rd(STATUS_OFFSET, 32'h0, 32'hc);
		end
		tick(2);
		close_out();
	end
endmodule // tb_pin_state_ctrl
